// ==== logic/hcap_top.sv ====
// Capability offset bank with AXI4-Lite slave and feature gating
`timescale 1ns/1ps
module hcap_top
   import hcap_pkg::*;
#(
   parameter int          NPORTS          = 4,
   parameter bit          VIRT_SUPPORT    = 1'b0,
   parameter logic [31:0] DB_OFFSET_BYTES = 32'h0000_3000,
   parameter logic [31:0] RT_OFFSET_BYTES = 32'h0000_2000,
   parameter logic [7:0]  FEATURE_CFG     = 8'hFF
) (
   // Clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0]       awaddr,
   input  wire logic [2:0]              awprot,
   input  wire logic                    awvalid,
   output logic                         awready,
   // AXI4-Lite write data
   input  wire logic [DATA_W-1:0]       wdata,
   input  wire logic [STRB_W-1:0]       wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   // AXI4-Lite write response
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0]       araddr,
   input  wire logic [2:0]              arprot,
   input  wire logic                    arvalid,
   output logic                         arready,
   // AXI4-Lite read data
   output logic [DATA_W-1:0]            rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   // Controller side, same clock
   input  wire logic [PAGE_SIZE_W-1:0]  memory_page_size,
   input  wire logic [NPORTS*LSF_W-1:0] link_state_field,
   input  wire logic                    save_state_req,
   // Feature effects
   output logic [NPORTS-1:0]            link_state_change_flag,
   output logic                         exit_latency_error_allowed,
   output logic                         compliance_allowed,
   output logic                         flush_cached_contexts
);

   hcap_cap_if cap ();

   hcap_word_gen #(
      .VIRT_SUPPORT    (VIRT_SUPPORT),
      .DB_OFFSET_BYTES (DB_OFFSET_BYTES),
      .RT_OFFSET_BYTES (RT_OFFSET_BYTES),
      .FEATURE_CFG     (FEATURE_CFG)
   ) u_words (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .memory_page_size (memory_page_size),
      .words            (cap.gen)
   );

   // ---------------- Write channel ----------------
   logic              awready_q, awready_d;
   logic              wready_q,  wready_d;
   logic              aw_held_q, aw_held_d;
   logic              w_held_q,  w_held_d;
   logic [ADDR_W-1:0] waddr_q,   waddr_d;
   logic [DATA_W-1:0] wdata_q,   wdata_d;
   logic [STRB_W-1:0] wstrb_q,   wstrb_d;
   logic              bvalid_q,  bvalid_d;
   logic [1:0]        bresp_q,   bresp_d;
   logic              wr_fire;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;

   always_comb begin
      logic aw_take;
      logic w_take;
      logic aw_have;
      logic w_have;
      aw_take   = awvalid && awready_q;
      w_take    = wvalid && wready_q;
      aw_have   = aw_held_q || aw_take;
      w_have    = w_held_q || w_take;
      aw_held_d = aw_have;
      w_held_d  = w_have;
      waddr_d   = aw_take ? awaddr : waddr_q;
      wdata_d   = w_take ? wdata : wdata_q;
      wstrb_d   = w_take ? wstrb : wstrb_q;
      wr_addr   = waddr_d;
      wr_data   = wdata_d;
      wr_strb   = wstrb_d;
      bvalid_d  = bvalid_q && !bready;
      bresp_d   = bresp_q;
      wr_fire   = 1'b0;
      // Address and data may arrive in either order; answer once both held
      if (aw_have && w_have && !bvalid_q) begin
         wr_fire   = 1'b1;
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         case (hcap_decode(wr_addr))
            // Read-only words accept the write and drop it
            REG_DOORBELL, REG_RUNTIME, REG_FEATURE:
               bresp_d = RESP_OKAY;
            REG_CONTROL, REG_EVENTS:                bresp_d = RESP_OKAY;
            default:                                bresp_d = RESP_SLVERR;
         endcase
      end
      awready_d = !aw_held_d && !bvalid_d;
      wready_d  = !w_held_d && !bvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         waddr_q   <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         awready_q <= awready_d;
         wready_q  <= wready_d;
         aw_held_q <= aw_held_d;
         w_held_q  <= w_held_d;
         waddr_q   <= waddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   // ---------------- Software control and event flags ----------------
   logic              exit_lat_en_q, exit_lat_en_d;
   logic              compl_en_q,    compl_en_d;
   logic [NPORTS-1:0] events_q,      events_d;
   logic [NPORTS-1:0] u3_entry;
   logic [NPORTS*LSF_W-1:0] prev_lsf_q;
   logic [NPORTS-1:0] lsc_q,         lsc_d;
   logic              elat_q,        elat_d;
   logic              compl_q,       compl_d;
   logic              flush_q,       flush_d;
   logic [7:0]        feat;

   assign feat = cap.feature_word[FEAT_W-1:0];

   // Each port flags only a fresh entry into U3, not a stay in it
   genvar gp;
   generate
      for (gp = 0; gp < NPORTS; gp++) begin : g_port
         assign u3_entry[gp] =
            feat[FB_SUSPEND_NOTIFY]
            && link_state_field[gp*LSF_W +: LSF_W] == LINK_U3
            && prev_lsf_q[gp*LSF_W +: LSF_W] != LINK_U3;
      end
   endgenerate

   always_comb begin
      logic [NPORTS-1:0] clr;
      exit_lat_en_d = exit_lat_en_q;
      compl_en_d    = compl_en_q;
      clr           = '0;
      if (wr_fire && wr_strb[0]) begin
         case (hcap_decode(wr_addr))
            REG_CONTROL: begin
               exit_lat_en_d = wr_data[CTRL_EXIT_LAT_EN];
               compl_en_d    = wr_data[CTRL_COMPL_EN];
            end
            REG_EVENTS: clr = wr_data[NPORTS-1:0];
            default: clr = '0;
         endcase
      end
      // A new entry in the clearing cycle survives the clear
      events_d = (events_q & ~clr) | u3_entry;
      lsc_d    = u3_entry;
      // Error may only be reported when both capable and enabled
      elat_d   = feat[FB_EXIT_LAT_ERR] && exit_lat_en_q;
      // Without the gate cap, compliance entry is always open
      compl_d  = !feat[FB_COMPL_GATE] || compl_en_q;
      flush_d  = save_state_req && feat[FB_FORCED_SAVE];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exit_lat_en_q <= 1'b0;
         compl_en_q    <= 1'b0;
         events_q      <= '0;
         prev_lsf_q    <= '0;
         lsc_q         <= '0;
         elat_q        <= 1'b0;
         compl_q       <= 1'b0;
         flush_q       <= 1'b0;
      end else begin
         exit_lat_en_q <= exit_lat_en_d;
         compl_en_q    <= compl_en_d;
         events_q      <= events_d;
         prev_lsf_q    <= link_state_field;
         lsc_q         <= lsc_d;
         elat_q        <= elat_d;
         compl_q       <= compl_d;
         flush_q       <= flush_d;
      end
   end

   // ---------------- Read channel ----------------
   logic              arready_q, arready_d;
   logic              rvalid_q,  rvalid_d;
   logic [DATA_W-1:0] rdata_q,   rdata_d;
   logic [1:0]        rresp_q,   rresp_d;

   always_comb begin
      rvalid_d = rvalid_q && !rready;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         case (hcap_decode(araddr))
            REG_DOORBELL: rdata_d = cap.doorbell_word;
            REG_RUNTIME:  rdata_d = cap.runtime_word;
            REG_FEATURE:  rdata_d = cap.feature_word;
            REG_CONTROL: begin
               rdata_d = '0;
               rdata_d[CTRL_EXIT_LAT_EN] = exit_lat_en_q;
               rdata_d[CTRL_COMPL_EN]    = compl_en_q;
            end
            REG_EVENTS: begin
               rdata_d = '0;
               rdata_d[NPORTS-1:0] = events_q;
            end
            default: begin
               rdata_d = '0;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
      // One read in flight; the next address waits for the data handshake
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign link_state_change_flag     = lsc_q;
   assign exit_latency_error_allowed = elat_q;
   assign compliance_allowed         = compl_q;
   assign flush_cached_contexts      = flush_q;

endmodule // hcap_top

// ==== logic/hcap_word_gen.sv ====
// Builds the doorbell, runtime and feature capability words
`timescale 1ns/1ps
module hcap_word_gen
   import hcap_pkg::*;
#(
   parameter bit          VIRT_SUPPORT    = 1'b0,
   parameter logic [31:0] DB_OFFSET_BYTES = 32'h0000_3000,
   parameter logic [31:0] RT_OFFSET_BYTES = 32'h0000_2000,
   parameter logic [7:0]  FEATURE_CFG     = 8'hFF
) (
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // Configured page size, one-hot, bit n means 4K << n
   input  wire logic [PAGE_SIZE_W-1:0] memory_page_size,
   // Words out
   hcap_cap_if.gen                     words
);

   logic [31:0] doorbell_q, doorbell_d;
   logic [31:0] runtime_q,  runtime_d;
   logic [31:0] feature_q,  feature_d;

   // Lowest set bit wins; an unset page size falls back to 4K
   function automatic logic [31:0] page_bytes(
      input logic [PAGE_SIZE_W-1:0] sel);
      logic [31:0] b;
      b = PAGE_UNIT;
      for (int i = PAGE_SIZE_W - 1; i >= 0; i--) begin
         if (sel[i]) begin
            b = PAGE_UNIT << i;
         end
      end
      return b;
   endfunction

   // Round up to a power-of-two boundary, then clear sub-unit bits
   function automatic logic [31:0] align_up(input logic [31:0] raw,
                                            input logic [31:0] unit);
      logic [31:0] m;
      m = unit - 32'h0000_0001;
      return (raw + m) & ~m;
   endfunction

   always_comb begin
      logic [31:0] pg;
      logic [7:0]  f;
      pg = page_bytes(memory_page_size);
      if (VIRT_SUPPORT) begin
         doorbell_d = align_up(DB_OFFSET_BYTES, pg) & DB_ALIGN_MASK;
         runtime_d  = align_up(RT_OFFSET_BYTES, pg) & RT_ALIGN_MASK;
      end else begin
         doorbell_d = DB_OFFSET_BYTES & DB_ALIGN_MASK;
         runtime_d  = align_up(RT_OFFSET_BYTES, ~RT_ALIGN_MASK
                               + 32'h0000_0001) & RT_ALIGN_MASK;
      end
      f = FEATURE_CFG;
      // A burst status cap without both prerequisites is never shown
      if (!(f[FB_LARGE_PAYLOAD] && f[FB_EXT_BURST])) begin
         f[FB_BURST_STATUS] = 1'b0;
      end
      feature_d = {24'h00_0000, f};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         doorbell_q <= 32'h0000_0000;
         runtime_q  <= 32'h0000_0000;
         // Fixed word stands from reset on, so gating never sees zeros
         feature_q  <= feature_d;
      end else begin
         doorbell_q <= doorbell_d;
         runtime_q  <= runtime_d;
         feature_q  <= feature_d;
      end
   end

   assign words.doorbell_word = doorbell_q;
   assign words.runtime_word  = runtime_q;
   assign words.feature_word  = feature_q;

endmodule // hcap_word_gen

// ==== shared/hcap_cap_if.sv ====
// Carrier for the three capability words
`timescale 1ns/1ps
interface hcap_cap_if;
   logic [31:0] doorbell_word;
   logic [31:0] runtime_word;
   logic [31:0] feature_word;

   modport gen (
      output doorbell_word,
      output runtime_word,
      output feature_word
   );
   modport use_words (
      input  doorbell_word,
      input  runtime_word,
      input  feature_word
   );
endinterface

// ==== shared/hcap_pkg.sv ====
// Constants, register map and decode helpers for the capability offset bank
// Notes on behaviour
// - Word 14h: doorbell offset in dwords, 1:0 zero
// - Doorbell dword aligned, page aligned with virtualization
// - Word 18h: runtime offset, 32-byte units, 4:0 zero
// - Runtime 32-byte aligned, page aligned with virtualization
// - Word 1Ch: fixed feature bits, 31:8 zero
// - Suspend notify cap: flag ports entering U3
// - Exit latency error only when cap and enable
// - Forced save cap: save writes all cached contexts
// - Bit 4 set iff payloads above 48K supported
// - Bit 5 set only if config fields honoured
// - Bit 6 reports burst counts beyond 65535
// - Bit 7 allowed only with bits 4 and 6
package hcap_pkg;

   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam int          STRB_W       = DATA_W / 8;
   localparam int          LSF_W        = 4;
   localparam int          PAGE_SIZE_W  = 16;
   localparam int          FEAT_W       = 8;

   // Register byte addresses
   localparam logic [7:0]  OFF_DOORBELL = 8'h14;
   localparam logic [7:0]  OFF_RUNTIME  = 8'h18;
   localparam logic [7:0]  OFF_FEATURE  = 8'h1C;
   localparam logic [7:0]  OFF_CONTROL  = 8'h20;
   localparam logic [7:0]  OFF_EVENTS   = 8'h24;

   // Alignment masks and page unit
   localparam logic [31:0] DB_ALIGN_MASK = 32'hFFFF_FFFC;
   localparam logic [31:0] RT_ALIGN_MASK = 32'hFFFF_FFE0;
   localparam logic [31:0] PAGE_UNIT     = 32'h0000_1000;

   // Feature word bit positions
   localparam int FB_SUSPEND_NOTIFY = 0;
   localparam int FB_EXIT_LAT_ERR   = 1;
   localparam int FB_FORCED_SAVE    = 2;
   localparam int FB_COMPL_GATE     = 3;
   localparam int FB_LARGE_PAYLOAD  = 4;
   localparam int FB_CONFIG_INFO    = 5;
   localparam int FB_EXT_BURST      = 6;
   localparam int FB_BURST_STATUS   = 7;

   // Control word bit positions
   localparam int CTRL_EXIT_LAT_EN  = 0;
   localparam int CTRL_COMPL_EN     = 1;

   localparam logic [3:0]  LINK_U3      = 4'h3;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [2:0] {
      REG_NONE,
      REG_DOORBELL,
      REG_RUNTIME,
      REG_FEATURE,
      REG_CONTROL,
      REG_EVENTS
   } hcap_reg_e;

   function automatic hcap_reg_e hcap_decode(input logic [ADDR_W-1:0] addr);
      hcap_reg_e r;
      case (addr)
         OFF_DOORBELL: r = REG_DOORBELL;
         OFF_RUNTIME:  r = REG_RUNTIME;
         OFF_FEATURE:  r = REG_FEATURE;
         OFF_CONTROL:  r = REG_CONTROL;
         OFF_EVENTS:   r = REG_EVENTS;
         default:      r = REG_NONE;
      endcase
      return r;
   endfunction

endpackage

// ==== testbench/hcap_checker.sv ====
// Concurrent checks on the capability offset bank ports
`timescale 1ns/1ps
module hcap_checker
   import hcap_pkg::*;
#(
   parameter int         NPORTS      = 4,
   parameter logic [7:0] FEATURE_CFG = 8'hFF
) (
   // Clock and reset
   input wire logic                    aclk,
   input wire logic                    aresetn,
   // Register bus
   input wire logic                    awvalid,
   input wire logic                    awready,
   input wire logic                    wvalid,
   input wire logic                    wready,
   input wire logic                    bvalid,
   input wire logic [ADDR_W-1:0]       araddr,
   input wire logic                    arvalid,
   input wire logic                    arready,
   input wire logic [DATA_W-1:0]       rdata,
   input wire logic [1:0]              rresp,
   input wire logic                    rvalid,
   input wire logic                    rready,
   // Controller side
   input wire logic [NPORTS*LSF_W-1:0] link_state_field,
   input wire logic                    save_state_req,
   input wire logic [NPORTS-1:0]       link_state_change_flag,
   input wire logic                    exit_latency_error_allowed,
   input wire logic                    compliance_allowed,
   input wire logic                    flush_cached_contexts
);
   // Bit 7 only survives alongside bits 4 and 6
   localparam logic [7:0] FEAT_EXP =
      {FEATURE_CFG[7] & FEATURE_CFG[6] & FEATURE_CFG[4], FEATURE_CFG[6:0]};

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic ar_fire;
   assign ar_fire = arvalid && arready;

   read_answer_a: assert property (ar_fire |=> rvalid)
      else $error("read answer missing");
   read_hold_a: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer not held");
   write_answer_a: assert property (awvalid && awready && wvalid && wready
      |=> bvalid) else $error("write response missing");
   doorbell_low_a: assert property (
      ar_fire && araddr == OFF_DOORBELL |=> rdata[1:0] == 2'h0)
      else $error("doorbell low bits set");
   runtime_low_a: assert property (
      ar_fire && araddr == OFF_RUNTIME |=> rdata[4:0] == 5'h00)
      else $error("runtime low bits set");
   feature_word_a: assert property (
      ar_fire && araddr == OFF_FEATURE |=> rdata == {24'h00_0000, FEAT_EXP})
      else $error("bad feature word");
   u3_flag_a: assert property (
      link_state_field[3:0] == LINK_U3
      && $past(link_state_field[3:0]) != LINK_U3
      |=> link_state_change_flag[0] == FEATURE_CFG[0])
      else $error("suspend entry flag wrong");
   ctx_flush_a: assert property (
      save_state_req |=> flush_cached_contexts == FEATURE_CFG[2])
      else $error("context flush wrong");
   exit_lat_a: assert property (
      exit_latency_error_allowed |-> FEATURE_CFG[1])
      else $error("exit latency error without cap");
   compliance_open_a: assert property (
      $past(aresetn) && !FEATURE_CFG[3] |-> compliance_allowed)
      else $error("compliance gated");

   cover property (ar_fire && araddr == OFF_FEATURE);
   cover property (|link_state_change_flag);
   cover property (flush_cached_contexts);
   cover property (exit_latency_error_allowed);
endmodule // hcap_checker

bind hcap_top hcap_checker #(.NPORTS(NPORTS), .FEATURE_CFG(FEATURE_CFG))
   chk_u (.*);

// ==== testbench/hcap_top_bench.sv ====
// Self-checking bench for the capability offset bank
`timescale 1ns/1ps
module hcap_top_bench;
   import hcap_pkg::*;

   // Odd offsets exercise the alignment; bit 7 set without bit 6
   localparam logic [7:0] FCFG = 8'h97;

   logic              aclk, aresetn;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [2:0]        awprot, arprot;
   logic [DATA_W-1:0] wdata, rdata;
   logic [STRB_W-1:0] wstrb;
   logic [1:0]        bresp, rresp;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [15:0]       memory_page_size, link_state_field;
   logic              save_state_req, flush_cached_contexts;
   logic [3:0]        link_state_change_flag;
   logic              exit_latency_error_allowed, compliance_allowed;
   int                n_fail, comparisons;
   logic [31:0]       d;
   logic [1:0]        r;
   logic [7:0]        ra [3] = '{OFF_DOORBELL, OFF_RUNTIME, OFF_FEATURE};
   logic [31:0]       rv [3] = '{32'h0000_3000, 32'h0000_2020,
                                 32'h0000_0017};

   hcap_top #(
      .DB_OFFSET_BYTES (32'h0000_3002),
      .RT_OFFSET_BYTES (32'h0000_2010),
      .FEATURE_CFG     (FCFG)
   ) dut_u (.*);

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string m);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t ns: %s", $time, m);
      end
   endtask

   task automatic close_out;
      $display("compared %0d, mismatched %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
      int t;
      bit aw_ok, w_ok;
      t = 0;
      aw_ok = 0;
      w_ok = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok) && t < 40) begin
         @(posedge aclk);
         t++;
         if (!aw_ok && awready) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
      end while (!bvalid && t < 80);
      rs = bresp;
      bready <= 1'b0;
      if (t >= 80) chk(32'h0, 32'h1, "write hang");
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      int t;
      t = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
      end while (!arready && t < 40);
      arvalid <= 1'b0;
      // Late ready makes the slave hold its answer for a cycle
      @(posedge aclk);
      t++;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
      end while (!rvalid && t < 80);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (t >= 80) chk(32'h0, 32'h1, "read hang");
   endtask

   initial begin
      #(25 * 4000);
      n_fail++;
      close_out();
   end

   initial begin
      {aresetn, awaddr, awprot, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arprot, arvalid, rready, save_state_req} = '0;
      wstrb = 4'hF;
      memory_page_size = 16'h0001;
      link_state_field = 16'h0000;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);

      for (int i = 0; i < 3; i++) begin
         rd(ra[i], d, r);
         chk(d, rv[i], "capability word");
         chk({30'h0, r}, {30'h0, RESP_OKAY}, "capability resp");
      end
      // The last word read is the feature word
      chk({31'h0, d[FB_LARGE_PAYLOAD]}, 32'h1, "payload bit");
      chk({31'h0, d[FB_CONFIG_INFO]}, 32'h0, "config bit");
      chk({31'h0, d[FB_EXT_BURST]}, 32'h0, "burst bit");
      chk({31'h0, d[FB_BURST_STATUS]}, 32'h0, "status bit");
      $display("test fixed words done");

      // Each word written with all ones, then read back unchanged
      for (int i = 0; i < 3; i++) begin
         wr(ra[i], 32'hFFFF_FFFF, r);
         chk({30'h0, r}, {30'h0, RESP_OKAY}, "ro write resp");
         rd(ra[i], d, r);
         chk(d, rv[i], "ro word changed");
      end
      $display("test read only done");

      rd(8'h40, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read resp");
      chk(d, 32'h0, "unmapped read data");
      wr(8'h15, 32'h1, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "misaligned write resp");
      $display("test unmapped done");

      wr(OFF_CONTROL, 32'h1, r);
      repeat (2) @(posedge aclk);
      chk({31'h0, exit_latency_error_allowed}, 32'h1, "elat on");
      chk({31'h0, compliance_allowed}, 32'h1, "compliance ungated");
      rd(OFF_CONTROL, d, r);
      chk(d, 32'h1, "control readback");
      wr(OFF_CONTROL, 32'h2, r);
      repeat (2) @(posedge aclk);
      chk({31'h0, exit_latency_error_allowed}, 32'h0, "elat off");
      chk({31'h0, compliance_allowed}, 32'h1, "compliance ungated");
      $display("test control done");

      // Ports 0 and 2 enter suspend, port 1 another state
      @(posedge aclk);
      link_state_field <= 16'h0353;
      repeat (2) @(posedge aclk);
      chk({28'h0, link_state_change_flag}, 32'h5, "u3 flag");
      @(posedge aclk);
      chk({28'h0, link_state_change_flag}, 32'h0, "u3 pulse");
      rd(OFF_EVENTS, d, r);
      chk(d, 32'h5, "event sticky");
      wr(OFF_EVENTS, 32'h5, r);
      rd(OFF_EVENTS, d, r);
      chk(d, 32'h0, "event cleared");
      $display("test suspend flag done");

      @(posedge aclk);
      save_state_req <= 1'b1;
      @(posedge aclk);
      save_state_req <= 1'b0;
      @(posedge aclk);
      chk({31'h0, flush_cached_contexts}, 32'h1, "flush");
      @(posedge aclk);
      chk({31'h0, flush_cached_contexts}, 32'h0, "flush pulse");
      $display("test save done");
      close_out();
   end
endmodule // hcap_top_bench
